// ==== hw/ocp_byte_reg.sv ====
// One byte-wide configuration register with reset value and writable-bit mask
`timescale 1ns/1ps
`default_nettype none

module ocp_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hff
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output var  logic [7:0] value_q
);

  // Bits outside the mask keep their reset level, so reserved bits never change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value_q <= RESET_VAL;
    end else if (wr_en) begin
      value_q <= (value_q & ~WR_MASK) | (wr_data & WR_MASK);
    end
  end

endmodule // ocp_byte_reg

`default_nettype wire

// ==== hw/ocp_pkg.sv ====
// Package: offsets, field layout, reset values and carrier types of the clock/pattern registers
package ocp_pkg;

  // Register count and printed indexes; byte address is four times the index
  localparam int          NUM_REGS   = 9;
  localparam int          IDX_W      = 30;
  localparam int          BYTE_SHIFT = 2;
  localparam logic [IDX_W-1:0] IDX_PHASE = 30'h016;
  localparam logic [IDX_W-1:0] IDX_DELAY = 30'h017;
  localparam logic [IDX_W-1:0] IDX_RSVD  = 30'h018;
  localparam logic [IDX_W-1:0] IDX_T1_LO = 30'h019;
  localparam logic [IDX_W-1:0] IDX_T1_HI = 30'h01a;
  localparam logic [IDX_W-1:0] IDX_T2_LO = 30'h01b;
  localparam logic [IDX_W-1:0] IDX_T2_HI = 30'h01c;
  localparam logic [IDX_W-1:0] IDX_T3_LO = 30'h01d;
  localparam logic [IDX_W-1:0] IDX_T3_HI = 30'h01e;
  localparam logic [IDX_W-1:0] IDX_FIRST = IDX_PHASE;

  // Slot numbers inside the register array, counted from the first index
  localparam int SLOT_PHASE = 0;
  localparam int SLOT_DELAY = 1;
  localparam int SLOT_RSVD  = 2;
  localparam int SLOT_T1_LO = 3;
  localparam int SLOT_T1_HI = 4;
  localparam int SLOT_T2_LO = 5;
  localparam int SLOT_T2_HI = 6;
  localparam int SLOT_T3_LO = 7;
  localparam int SLOT_T3_HI = 8;

  // Field positions
  localparam int PH_INV_BIT    = 4;
  localparam int PH_COARSE_LSB = 0;
  localparam int DL_EN_BIT     = 7;
  localparam int DL_CODE_LSB   = 0;
  localparam int DL_CODE_W     = 5;
  localparam int STEPS_W       = 6;

  // Reset values and writable-bit masks; unlisted bits read zero
  localparam logic [7:0] RST_PHASE  = 8'h00;
  localparam logic [7:0] RST_DELAY  = 8'h00;
  localparam logic [7:0] RST_RSVD   = 8'h04;
  localparam logic [7:0] RST_PATT   = 8'h00;
  localparam logic [7:0] MASK_PHASE = 8'h13;
  localparam logic [7:0] MASK_DELAY = 8'h9f;
  localparam logic [7:0] MASK_FULL  = 8'hff;

  // Fine delay step of the output data clock
  localparam int DELAY_STEP_PS = 100;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Coarse phase codes of the output data clock against the data lanes
  typedef enum logic [1:0] {
    OCP_PH_PLUS90 = 2'b00,
    OCP_PH_ZERO_A = 2'b01,
    OCP_PH_ZERO_B = 2'b10,
    OCP_PH_MINUS90 = 2'b11
  } ocp_phase_t;

  // Bus slave states
  typedef enum logic [0:0] {
    OCP_BUS_IDLE = 1'b0,
    OCP_BUS_DATA = 1'b1
  } ocp_bus_state_t;

  // Settings for the output data clock stage
  typedef struct packed {
    logic               invert;
    ocp_phase_t         coarse;
    logic signed [1:0]  quarter;
    logic               delay_en;
    logic [DL_CODE_W-1:0] delay_code;
    logic [STEPS_W-1:0] delay_steps;
  } ocp_clk_cfg_t;

  // The three user test words
  typedef struct packed {
    logic [15:0] word_one;
    logic [15:0] word_two;
    logic [15:0] word_three;
  } ocp_patt_t;

endpackage

// ==== hw/ocp_regs.sv ====
// Output clock phase, fine delay and user test pattern registers behind an AHB-Lite slave
//
// Function
// [R1] Bit 4 of phase register inverts the output data clock; reset zero.
// [R2] Bits 1:0 set coarse clock phase: 00 +90, 01/10 zero, 11 -90 degrees.
// [R3] Bit 7 of delay register enables fine clock delay; reset disabled.
// [R4] Five-bit delay code picks 100 ps steps, 00000 is 100 ps, 11111 3.2 ns.
// [R5] Test word one: low byte at 0x019, high byte at 0x01A, reset zero.
// [R6] Test word two: low byte at 0x01B, high byte at 0x01C, reset zero.
// [R7] Test word three: low byte at 0x01D, high byte at 0x01E, reset zero.
// [R8] Software leaves reserved register 0x018 at its reset value.
//
// Each transfer has one wait state: the address is taken at one edge, the
// byte register changes at the next, and clk_cfg and patterns follow one
// edge after that. Reads return the byte in hrdata[7:0] with upper bits zero.
// Unmapped or misaligned addresses and non-word writes are ignored, always
// with an OKAY response.
`timescale 1ns/1ps
`default_nettype none

module ocp_regs #(
  parameter int DELAY_STEP_PS = ocp_pkg::DELAY_STEP_PS
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic              hreadyout,
  output var  logic              hresp,
  output var  logic [31:0]       hrdata,
  output var  ocp_pkg::ocp_clk_cfg_t clk_cfg,
  output var  ocp_pkg::ocp_patt_t    patterns
);

  // Elaboration checks. The step size only scales the reported delay, so a
  // zero step is meaningless; the slot decode is four bits wide, so the map
  // must fit it; the step count needs one bit more than the delay code
  if (DELAY_STEP_PS <= 0) begin : g_bad_step
    $error("DELAY_STEP_PS must be positive");
  end
  if (ocp_pkg::NUM_REGS > 16) begin : g_bad_count
    $error("register count exceeds the slot decode");
  end
  if (int'(ocp_pkg::IDX_T3_HI - ocp_pkg::IDX_FIRST) + 1 != ocp_pkg::NUM_REGS) begin : g_bad_map
    $error("register map and register count disagree");
  end
  if (ocp_pkg::STEPS_W <= ocp_pkg::DL_CODE_W) begin : g_bad_steps
    $error("step count too narrow for the delay code");
  end
  if (ocp_pkg::PH_INV_BIT > 7 || ocp_pkg::DL_EN_BIT > 7) begin : g_bad_bit
    $error("control bit outside a byte register");
  end

  // Decode helpers

  // Word index carried by a byte address
  function automatic logic [ocp_pkg::IDX_W-1:0] word_index(input logic [31:0] addr);
    word_index = addr[31:ocp_pkg::BYTE_SHIFT];
  endfunction

  // True when an address hits one of the mapped registers, word aligned
  function automatic logic addr_mapped(input logic [31:0] addr);
    logic [ocp_pkg::IDX_W-1:0] idx;
    idx = word_index(addr);
    addr_mapped = (addr[ocp_pkg::BYTE_SHIFT-1:0] == 2'h0)
               && (idx >= ocp_pkg::IDX_PHASE)
               && (idx <= ocp_pkg::IDX_T3_HI);
  endfunction

  // Slot of a mapped address inside the register array
  function automatic logic [3:0] addr_slot(input logic [31:0] addr);
    logic [ocp_pkg::IDX_W-1:0] diff;
    diff = word_index(addr) - ocp_pkg::IDX_FIRST;
    addr_slot = diff[3:0];
  endfunction

  // Coarse phase code to signed quarter cycles of the output data clock
  function automatic logic signed [1:0] phase_quarters(input ocp_pkg::ocp_phase_t code);
    logic signed [1:0] q;
    q = 2'sb00;
    unique case (code)
      ocp_pkg::OCP_PH_PLUS90:  q = 2'sb01;
      ocp_pkg::OCP_PH_ZERO_A:  q = 2'sb00;
      ocp_pkg::OCP_PH_ZERO_B:  q = 2'sb00;
      ocp_pkg::OCP_PH_MINUS90: q = 2'sb11;
    endcase
    phase_quarters = q;
  endfunction

  // Bus slave state

  ocp_pkg::ocp_bus_state_t state_q;
  ocp_pkg::ocp_bus_state_t state_d;
  logic                    hit_q;
  logic [3:0]              slot_q;
  logic                    write_q;
  logic                    word_q;
  logic                    addr_take;
  logic                    ready_q;
  logic [31:0]             rdata_q;

  // Register array contents and per-slot write strobes
  logic [7:0]              reg_val [ocp_pkg::NUM_REGS];
  logic [ocp_pkg::NUM_REGS-1:0] reg_we;

  // An address phase is taken only when the bus is ready and a real transfer is offered
  assign addr_take = hsel && hready && htrans[1];

  // Every transfer gets one wait state; this lets the write data land before
  // a following read samples the array, so no read-after-write bypass is needed
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ocp_pkg::OCP_BUS_IDLE: begin
        if (addr_take) begin
          state_d = ocp_pkg::OCP_BUS_DATA;
        end
      end
      ocp_pkg::OCP_BUS_DATA: begin
        state_d = ocp_pkg::OCP_BUS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ocp_pkg::OCP_BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Address phase capture: which register the pending data phase touches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_q  <= 1'b0;
      slot_q <= 4'h0;
    end else if (addr_take && state_q == ocp_pkg::OCP_BUS_IDLE) begin
      hit_q  <= addr_mapped(haddr);
      slot_q <= addr_slot(haddr);
    end
  end

  // Address phase capture: direction and size; a narrow write is dropped
  // rather than merged, since every register is one whole word to software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      write_q <= 1'b0;
      word_q  <= 1'b0;
    end else if (addr_take && state_q == ocp_pkg::OCP_BUS_IDLE) begin
      write_q <= hwrite;
      word_q  <= (hsize == ocp_pkg::HSIZE_WORD);
    end
  end

  // Ready drops for the wait state and rises for the closing cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
    end else if (state_q == ocp_pkg::OCP_BUS_IDLE && addr_take) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
    end
  end

  // Read data is loaded in the wait state; unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (state_q == ocp_pkg::OCP_BUS_DATA) begin
      if (!write_q && hit_q) begin
        rdata_q <= {24'h00_0000, reg_val[slot_q]};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign hreadyout = ready_q;
  assign hrdata    = rdata_q;

  // Every answer is OKAY, so the error level is a constant flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Register array

  // Write strobes: only whole-word writes to a mapped slot, in the wait state
  always_comb begin
    reg_we = '0;
    if (state_q == ocp_pkg::OCP_BUS_DATA && write_q && word_q && hit_q) begin
      reg_we[slot_q] = 1'b1;
    end
  end

  // Reset value and writable mask per slot
  function automatic logic [7:0] slot_reset(input int s);
    if (s == ocp_pkg::SLOT_PHASE) begin
      slot_reset = ocp_pkg::RST_PHASE;
    end else if (s == ocp_pkg::SLOT_DELAY) begin
      slot_reset = ocp_pkg::RST_DELAY;
    end else if (s == ocp_pkg::SLOT_RSVD) begin
      slot_reset = ocp_pkg::RST_RSVD;
    end else begin
      slot_reset = ocp_pkg::RST_PATT;
    end
  endfunction

  function automatic logic [7:0] slot_mask(input int s);
    if (s == ocp_pkg::SLOT_PHASE) begin
      slot_mask = ocp_pkg::MASK_PHASE;
    end else if (s == ocp_pkg::SLOT_DELAY) begin
      slot_mask = ocp_pkg::MASK_DELAY;
    end else begin
      slot_mask = ocp_pkg::MASK_FULL;
    end
  endfunction

  // One byte register per slot; the reserved slot keeps its own value and is
  // merely stored, it steers nothing here  [R8]
  genvar g;
  generate
    for (g = 0; g < ocp_pkg::NUM_REGS; g++) begin : g_reg
      ocp_byte_reg #(
        .RESET_VAL (slot_reset(g)),
        .WR_MASK   (slot_mask(g))
      ) u_reg (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (reg_we[g]),
        .wr_data (hwdata[7:0]),
        .value_q (reg_val[g])
      );
    end
  endgenerate

  // Output data clock settings

  logic [7:0]               phase_reg;
  logic [7:0]               delay_reg;
  ocp_pkg::ocp_phase_t      coarse_code;
  logic [ocp_pkg::DL_CODE_W-1:0] delay_code;

  assign phase_reg   = reg_val[ocp_pkg::SLOT_PHASE];
  assign delay_reg   = reg_val[ocp_pkg::SLOT_DELAY];
  assign coarse_code = ocp_pkg::ocp_phase_t'(phase_reg[ocp_pkg::PH_COARSE_LSB +: 2]);
  assign delay_code  = delay_reg[ocp_pkg::DL_CODE_LSB +: ocp_pkg::DL_CODE_W];

  // Inversion applies to the one output clock shared by all channels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_cfg.invert <= 1'b0;
    end else begin
      clk_cfg.invert <= phase_reg[ocp_pkg::PH_INV_BIT]; // [R1]
    end
  end

  // Coarse phase, raw; both zero codes are kept apart in the raw field so
  // software reads back exactly what it wrote
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_cfg.coarse <= ocp_pkg::OCP_PH_PLUS90;
    end else begin
      clk_cfg.coarse <= coarse_code; // [R2]
    end
  end

  // Quarter-cycle meaning of the coarse code; reset matches the +90 code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_cfg.quarter <= 2'sb01;
    end else begin
      clk_cfg.quarter <= phase_quarters(coarse_code); // [R2]
    end
  end

  // Fine delay enable and raw code, as written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_cfg.delay_en   <= 1'b0;
      clk_cfg.delay_code <= '0;
    end else begin
      clk_cfg.delay_en   <= delay_reg[ocp_pkg::DL_EN_BIT]; // [R3]
      clk_cfg.delay_code <= delay_code;                    // [R4]
    end
  end

  // Delay in steps of the step size. Code zero already means one step, so an
  // enabled delay is never zero; zero steps stands for a disabled delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_cfg.delay_steps <= '0;
    end else if (delay_reg[ocp_pkg::DL_EN_BIT]) begin
      clk_cfg.delay_steps <= {1'b0, delay_code} + 6'h01; // [R4]
    end else begin
      clk_cfg.delay_steps <= 6'h00;                      // [R3]
    end
  end

  // User test words, assembled from their byte halves

  // Halves are written separately, so a word may briefly show one old half;
  // software that needs a clean switch writes the pattern while it is unused
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      patterns.word_one <= '0;
    end else begin
      patterns.word_one <= {reg_val[ocp_pkg::SLOT_T1_HI],
                            reg_val[ocp_pkg::SLOT_T1_LO]}; // [R5]
    end
  end

  // Test word two from its byte halves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      patterns.word_two <= '0;
    end else begin
      patterns.word_two <= {reg_val[ocp_pkg::SLOT_T2_HI],
                            reg_val[ocp_pkg::SLOT_T2_LO]}; // [R6]
    end
  end

  // Test word three from its byte halves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      patterns.word_three <= '0;
    end else begin
      patterns.word_three <= {reg_val[ocp_pkg::SLOT_T3_HI],
                              reg_val[ocp_pkg::SLOT_T3_LO]}; // [R7]
    end
  end

endmodule // ocp_regs

`default_nettype wire

// ==== tb/ocp_host.sv ====
// Host controller model: single-word AHB-Lite master
`timescale 1ns/1ps
`default_nettype none

module ocp_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata
);
  // Bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
  end

  // Ready is sampled at the rising edge, before the slave's flops update there
  task automatic wait_rdy();
    @(posedge hclk);
    while (!hready) @(posedge hclk);
  endtask

  // One transfer; called just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= ocp_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= ocp_pkg::HSIZE_WORD;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    hwdata <= ~d; // Stale data is not left looking valid
  endtask
endmodule // ocp_host

`default_nettype wire

// ==== tb/ocp_regs_asserts.sv ====
// Checker for the output clock phase and test pattern register slave
`timescale 1ns/1ps
`default_nettype none

module ocp_regs_asserts (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  input wire ocp_pkg::ocp_clk_cfg_t clk_cfg,
  input wire ocp_pkg::ocp_patt_t    patterns
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Accepted address phases; a write lands one edge later, outputs one more
  logic tk;
  logic tw;
  assign tk = hsel && hready && htrans[1] && hreadyout;
  assign tw = tk && hwrite && hsize == 3'h2;

  AST_ONE_WAIT: assert property (tk |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  AST_INV: assert property (tw && haddr == 32'h58 |-> ##3 clk_cfg.invert == $past(hwdata[4], 2))
    else $error("clock inversion does not follow write");
  AST_COARSE: assert property (tw && haddr == 32'h58 |->
    ##3 clk_cfg.coarse == $past(hwdata[1:0], 2))
    else $error("coarse phase does not follow write");
  AST_QUARTER: assert property (clk_cfg.quarter == (clk_cfg.coarse == 2'h0 ? 2'h1 :
    clk_cfg.coarse == 2'h3 ? 2'h3 : 2'h0))
    else $error("quarter step wrong for coarse code");
  AST_DELAY: assert property (tw && haddr == 32'h5c |-> ##3
    {clk_cfg.delay_en, clk_cfg.delay_code} == {$past(hwdata[7], 2), $past(hwdata[4:0], 2)})
    else $error("delay fields do not follow write");
  AST_STEPS: assert property (clk_cfg.delay_steps ==
    (clk_cfg.delay_en ? {1'b0, clk_cfg.delay_code} + 6'h01 : 6'h00))
    else $error("delay steps wrong");
  AST_T1_LO: assert property (tw && haddr == 32'h64 |->
    ##3 patterns.word_one[7:0] == $past(hwdata[7:0], 2))
    else $error("word one low byte does not follow write");
  AST_T2_RD: assert property (tk && !hwrite && haddr == 32'h6c |->
    ##2 hrdata == {24'h0, patterns.word_two[7:0]})
    else $error("word two low byte reads wrong");
  AST_T3_RD: assert property (tk && !hwrite && haddr == 32'h78 |->
    ##2 hrdata == {24'h0, patterns.word_three[15:8]})
    else $error("word three high byte reads wrong");

  // Main scenarios reached
  COV_PHASE_WR: cover property (tw && haddr == 32'h58);
  COV_MAX_DELAY: cover property (clk_cfg.delay_steps == 6'h20);
  COV_RSVD_RD: cover property (tk && !hwrite && haddr == 32'h60);
endmodule // ocp_regs_asserts

bind ocp_regs ocp_regs_asserts i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .clk_cfg(clk_cfg), .patterns(patterns));

`default_nettype wire

// ==== tb/ocp_regs_test.sv ====
// Self-checking test of the output clock phase and test pattern registers
`timescale 1ns/1ps
`default_nettype none

module ocp_regs_test;
  logic                  hclk = 1'b0;
  logic                  hresetn = 1'b0;
  logic                  hsel;
  logic                  hwrite;
  logic                  hreadyout;
  logic                  hresp;
  logic [31:0]           haddr;
  logic [31:0]           hwdata;
  logic [31:0]           hrdata;
  logic [31:0]           v;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  ocp_pkg::ocp_clk_cfg_t clk_cfg;
  ocp_pkg::ocp_patt_t    patterns;
  int                    miscompares = 0;
  int                    comparisons = 0;
  int                    cyc = 0;
  logic [7:0]            rstv [9] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]            dl [3] = '{8'h7f, 8'h80, 8'hff};

  always #12.5 hclk = ~hclk;

  ocp_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .clk_cfg(clk_cfg), .patterns(patterns));
  ocp_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Slot i sits at index 0x016+i, byte address four times that
  task automatic wr(input int i, input logic [7:0] d);
    i_host.xfer(1'b1, 32'h58 + 32'(i * 4), {24'h0, d}, v);
  endtask
  task automatic rd(input int i);
    i_host.xfer(1'b0, 32'h58 + 32'(i * 4), 32'h0, v);
  endtask
  function automatic logic [7:0] pv(input int i);
    return 8'(i * 37 + 3);
  endfunction

  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard, generous against about 120 cycles of traffic
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Every register at its reset value; the reserved one is only read
    for (int i = 0; i < 9; i++) begin
      rd(i);
      chk("reset value", v, {24'h0, rstv[i]});
    end
    chk("quarter at reset", 32'(clk_cfg.quarter), 32'h1);
    // Each coarse code, inversion set for the odd codes only; unwritable bits set too
    for (int c = 0; c < 4; c++) begin
      wr(0, {3'h7, c[0], 2'h3, c[1:0]});
      rd(0);
      chk("phase reg", v, {27'h0, c[0], 2'h0, c[1:0]});
      chk("invert", 32'(clk_cfg.invert), 32'(c[0]));
      chk("coarse", 32'(clk_cfg.coarse), 32'(c[1:0]));
      chk("quarter", 32'(clk_cfg.quarter), c == 0 ? 32'h1 : c == 3 ? 32'hffffffff : 32'h0);
    end
    // Delay off with all code bits, then smallest and largest codes on
    for (int k = 0; k < 3; k++) begin
      wr(1, dl[k]);
      rd(1);
      chk("delay reg", v, {24'h0, dl[k] & 8'h9f});
      chk("delay en code", {clk_cfg.delay_en, clk_cfg.delay_code}, {dl[k][7], dl[k][4:0]});
      chk("steps", 32'(clk_cfg.delay_steps), dl[k][7] ? 32'(dl[k][4:0]) + 32'h1 : 32'h0);
    end
    // Six pattern bytes back to back, then read back
    for (int i = 3; i < 9; i++) wr(i, pv(i));
    for (int i = 3; i < 9; i++) begin
      rd(i);
      chk("pattern byte", v, {24'h0, pv(i)});
    end
    chk("word one", 32'(patterns.word_one), {16'h0, pv(4), pv(3)});
    chk("word two", 32'(patterns.word_two), {16'h0, pv(6), pv(5)});
    chk("word three", 32'(patterns.word_three), {16'h0, pv(8), pv(7)});
    // Unmapped place: write ignored, reads zero
    i_host.xfer(1'b1, 32'h7c, 32'hff, v);
    i_host.xfer(1'b0, 32'h7c, 32'h0, v);
    chk("unmapped", v, 32'h0);
    chk("word three kept", 32'(patterns.word_three), {16'h0, pv(8), pv(7)});
    // Reset in mid-run restores defaults
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8);
    chk("word three high after reset", v, 32'h0);
    rd(1);
    chk("delay after reset", v, 32'h0);
    chk("quarter after reset", 32'(clk_cfg.quarter), 32'h1);
    chk("word one after reset", 32'(patterns.word_one), 32'h0);
    summarize();
  end
endmodule // ocp_regs_test

`default_nettype wire
